/* File: include/nested_irq_pkg.sv */
// constants for the interrupt priority and external sensitivity block
// assumes a single cpu clock domain shared with the core
package nested_irq_pkg;
  localparam int unsigned NUM_VEC = 14;
  localparam int unsigned NUM_PINS = 16;
  localparam int unsigned NUM_GRP = 3;
  // register indices on the plain register port
  localparam logic [2:0] ADDR_PRIO0 = 3'h0;
  localparam logic [2:0] ADDR_PRIO1 = 3'h1;
  localparam logic [2:0] ADDR_PRIO2 = 3'h2;
  localparam logic [2:0] ADDR_PRIO3 = 3'h3;
  localparam logic [2:0] ADDR_SENSE = 3'h4;
  localparam logic [7:0] PRIO_RESET = 8'hff;
  localparam logic [7:0] PRIO3_RO_MASK = 8'hf0;
  localparam logic [7:0] SENSE_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // level codes as held in the cpu current-level bits
  localparam logic [1:0] CODE_L0 = 2'h2;
  localparam logic [1:0] CODE_L1 = 2'h1;
  localparam logic [1:0] CODE_L2 = 2'h0;
  localparam logic [1:0] CODE_L3 = 2'h3;
  // sensitivity codes
  localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
  localparam logic [1:0] SENSE_RISE = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;
  // sensitivity register fields
  localparam int unsigned G2_SENSE_LSB = 6;
  localparam int unsigned G2_POL_BIT = 5;
  localparam int unsigned G1_SENSE_LSB = 3;
  localparam int unsigned G0_SENSE_LSB = 1;
  localparam int unsigned G0_POL_BIT = 0;
  // vector numbers
  localparam logic [3:0] VEC_ESTOP = 4'h0;
  localparam logic [3:0] VEC_CLK = 4'h1;
  localparam logic [3:0] VEC_EXT0 = 4'h2;
  localparam logic [3:0] VEC_EXT1 = 4'h3;
  localparam logic [3:0] VEC_EXT2 = 4'h4;
  localparam logic [15:0] VEC_ADDR_RESET = 16'hfffe;
  localparam logic [15:0] VEC_ADDR_TRAP = 16'hfffc;
  localparam logic [15:0] VEC_ADDR_SRC0 = 16'hfffa;
  // sources able to leave halt, and those leaving active-halt only
  localparam logic [13:0] HALT_WAKE_MASK = 14'h111c;
  localparam logic [13:0] AHALT_ONLY_MASK = 14'h0002;
  // pin to group map: group0 pins 0..5, group1 pins 6..9, group2 pins 10..15
  localparam logic [15:0] G0_PINS = 16'h003f;
  localparam logic [15:0] G1_PINS = 16'h03c0;
  localparam logic [15:0] G2_PINS = 16'hfc00;
  // pins whose sensitivity follows a polarity bit
  localparam logic [15:0] G0_POL_PINS = 16'h0038;
  localparam logic [15:0] G2_POL_PINS = 16'h1c00;
endpackage

/* File: rtl/nested_irq_prio.sv */
// priority registers, current level, vector map and external sensitivity
// assumes the core gives one-cycle instruction and service-entry strobes
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
module nested_irq_prio (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic svc_entry_in,
  input wire logic svc_nonmask_in,
  input wire logic [3:0] svc_vector_in,
  input wire logic svc_pending_in,
  input wire logic enable_irq_instr_in,
  input wire logic disable_irq_instr_in,
  input wire logic trap_instr_in,
  input wire logic halt_instr_in,
  input wire logic wait_instr_in,
  input wire logic irq_return_instr_in,
  input wire logic pop_cc_instr_in,
  input wire logic [1:0] stacked_level_in,
  input wire logic [15:0] ext_pin_in,
  input wire logic [15:0] pin_irq_en_in,
  input wire logic [15:0] pin_forced_low_in,
  input wire logic [13:0] src_req_in,
  output logic cur_level_hi_bit_out,
  output logic cur_level_lo_bit_out,
  output logic branch_if_level3_out,
  output logic branch_if_not_level3_out,
  output logic [27:0] arb_prio_codes_out,
  output logic reenter_req_out,
  output logic [15:0] svc_vector_addr_out,
  output logic [2:0] ext_req_out,
  output logic halt_wake_out,
  output logic active_halt_wake_out
);

  // level number from pair code, higher means more urgent
  function automatic logic [1:0] code_to_level(input logic [1:0] code);
    case (code)
      nested_irq_pkg::CODE_L0: code_to_level = 2'h0;
      nested_irq_pkg::CODE_L1: code_to_level = 2'h1;
      nested_irq_pkg::CODE_L2: code_to_level = 2'h2;
      default: code_to_level = 2'h3;
    endcase
  endfunction

  // merge a write into a priority register, keeping pairs that carry level 0
  function automatic logic [7:0] merge_prio(input logic [7:0] old, input logic [7:0] wr);
    logic [7:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (wr[2*i +: 2] != nested_irq_pkg::CODE_L0)
      begin
        res[2*i +: 2] = wr[2*i +: 2];
      end
    end
    merge_prio = res;
  endfunction

  // edge and level detection for one pin
  function automatic logic [1:0] detect(input logic [1:0] sense, input logic inv,
                                        input logic now, input logic prev);
    logic rise;
    logic fall;
    logic [1:0] res;
    rise = now & ~prev;
    fall = ~now & prev;
    res = 2'h0;
    case (sense)
      nested_irq_pkg::SENSE_FALL_LOW: res = inv ? {rise, now} : {fall, ~now};
      nested_irq_pkg::SENSE_RISE: res = {(inv ? fall : rise), 1'b0};
      nested_irq_pkg::SENSE_FALL: res = {(inv ? rise : fall), 1'b0};
      default: res = {(rise | fall), 1'b0};
    endcase
    detect = res;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // priority registers

  logic [7:0] prio [4];
  logic [7:0] sense_ctrl;
  logic [1:0] cur_level;
  logic wr_prio;
  logic wr_sense;
  logic sense_change;
  logic [7:0] next_sense;

  assign wr_prio = ce_in & reg_wr_in & (reg_addr_in <= nested_irq_pkg::ADDR_PRIO3);
  assign wr_sense = ce_in & reg_wr_in & (reg_addr_in == nested_irq_pkg::ADDR_SENSE);

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < 4; i++)
      begin
        prio[i] <= nested_irq_pkg::PRIO_RESET;
      end
    end
    else if (wr_prio)
    begin
      prio[reg_addr_in[1:0]] <= merge_prio(prio[reg_addr_in[1:0]], reg_wdata_in);
    end
  end

  // upper nibble of the last register is held at ones
  function automatic logic [7:0] prio_view(input logic [1:0] idx, input logic [7:0] val);
    prio_view = (idx == 2'h3) ? (val | nested_irq_pkg::PRIO3_RO_MASK) : val;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // sensitivity register

  assign next_sense = reg_wdata_in;
  assign sense_change = wr_sense & (cur_level == nested_irq_pkg::CODE_L3)
                        & (next_sense != sense_ctrl);

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sense_ctrl <= nested_irq_pkg::SENSE_RESET;
    end
    else if (wr_sense && cur_level == nested_irq_pkg::CODE_L3)
    begin
      sense_ctrl <= next_sense;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register read port

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      reg_rdata_out <= nested_irq_pkg::READ_UNMAPPED;
    end
    else if (ce_in)
    begin
      if (!reg_rd_in)
      begin
        reg_rdata_out <= nested_irq_pkg::READ_UNMAPPED;
      end
      else if (reg_addr_in <= nested_irq_pkg::ADDR_PRIO3)
      begin
        reg_rdata_out <= prio_view(reg_addr_in[1:0], prio[reg_addr_in[1:0]]);
      end
      else if (reg_addr_in == nested_irq_pkg::ADDR_SENSE)
      begin
        reg_rdata_out <= sense_ctrl;
      end
      else
      begin
        reg_rdata_out <= nested_irq_pkg::READ_UNMAPPED;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-vector codes and current level

  logic [1:0] vec_code [nested_irq_pkg::NUM_VEC];

  always_comb
  begin
    for (int v = 0; v < nested_irq_pkg::NUM_VEC; v++)
    begin
      vec_code[v] = prio[v / 4][2 * (v % 4) +: 2];
      arb_prio_codes_out[2*v +: 2] = vec_code[v];
    end
    arb_prio_codes_out[1:0] = nested_irq_pkg::CODE_L3;
  end

  logic svc_top;
  assign svc_top = svc_nonmask_in | (svc_vector_in == nested_irq_pkg::VEC_ESTOP);

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cur_level <= nested_irq_pkg::CODE_L3;
    end
    else if (ce_in)
    begin
      if (svc_entry_in && svc_top)
      begin
        cur_level <= nested_irq_pkg::CODE_L3;
      end
      else if (svc_entry_in)
      begin
        cur_level <= vec_code[svc_vector_in];
      end
      else if (disable_irq_instr_in || trap_instr_in)
      begin
        cur_level <= nested_irq_pkg::CODE_L3;
      end
      else if (enable_irq_instr_in || halt_instr_in || wait_instr_in)
      begin
        cur_level <= nested_irq_pkg::CODE_L0;
      end
      else if (irq_return_instr_in || pop_cc_instr_in)
      begin
        cur_level <= stacked_level_in;
      end
    end
  end

  assign cur_level_hi_bit_out = cur_level[1];
  assign cur_level_lo_bit_out = cur_level[0];
  assign branch_if_level3_out = (cur_level == nested_irq_pkg::CODE_L3);
  assign branch_if_not_level3_out = (cur_level != nested_irq_pkg::CODE_L3);

  // active maskable vector, captured at entry
  logic [3:0] active_vec;
  logic active_maskable;

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      active_vec <= nested_irq_pkg::VEC_ESTOP;
      active_maskable <= 1'b0;
    end
    else if (ce_in && svc_entry_in)
    begin
      active_vec <= svc_vector_in;
      active_maskable <= ~svc_top;
    end
    else if (ce_in && irq_return_instr_in)
    begin
      active_maskable <= 1'b0;
    end
  end

  assign reenter_req_out = active_maskable & svc_pending_in
    & (code_to_level(vec_code[active_vec]) > code_to_level(cur_level));

  assign svc_vector_addr_out = svc_nonmask_in
    ? (svc_vector_in[0] ? nested_irq_pkg::VEC_ADDR_TRAP : nested_irq_pkg::VEC_ADDR_RESET)
    : nested_irq_pkg::VEC_ADDR_SRC0 - {11'h000, svc_vector_in, 1'b0};

  //////////////////////////////////////////////////////////////////////////
  // external pins

  logic [15:0] pin_meta;
  logic [15:0] pin_sync;
  logic [15:0] pin_prev;

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_meta <= 16'hffff;
      pin_sync <= 16'hffff;
      pin_prev <= 16'hffff;
    end
    else if (ce_in)
    begin
      pin_meta <= ext_pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  logic [15:0] pin_edge;
  logic [15:0] pin_level;
  logic [1:0] pin_det;
  logic [1:0] pin_sense;
  logic pin_inv;

  always_comb
  begin
    pin_edge = 16'h0000;
    pin_level = 16'h0000;
    pin_det = 2'h0;
    pin_sense = 2'h0;
    pin_inv = 1'b0;
    for (int p = 0; p < nested_irq_pkg::NUM_PINS; p++)
    begin
      if (nested_irq_pkg::G2_PINS[p])
      begin
        pin_sense = sense_ctrl[nested_irq_pkg::G2_SENSE_LSB +: 2];
        pin_inv = sense_ctrl[nested_irq_pkg::G2_POL_BIT]
                  & nested_irq_pkg::G2_POL_PINS[p];
      end
      else if (nested_irq_pkg::G1_PINS[p])
      begin
        pin_sense = sense_ctrl[nested_irq_pkg::G1_SENSE_LSB +: 2];
        pin_inv = 1'b0;
      end
      else
      begin
        pin_sense = sense_ctrl[nested_irq_pkg::G0_SENSE_LSB +: 2];
        pin_inv = sense_ctrl[nested_irq_pkg::G0_POL_BIT]
                  & nested_irq_pkg::G0_POL_PINS[p];
      end
      pin_det = detect(pin_sense, pin_inv, pin_sync[p], pin_prev[p]);
      pin_edge[p] = pin_det[1] & pin_irq_en_in[p];
      pin_level[p] = pin_det[0] & pin_irq_en_in[p];
    end
  end

  logic [15:0] grp_pins [nested_irq_pkg::NUM_GRP];
  assign grp_pins[0] = nested_irq_pkg::G0_PINS;
  assign grp_pins[1] = nested_irq_pkg::G1_PINS;
  assign grp_pins[2] = nested_irq_pkg::G2_PINS;

  logic [2:0] ext_pend;
  logic [2:0] grp_set;
  logic [2:0] grp_level;
  logic [2:0] grp_mask;
  logic [2:0] grp_ack;

  always_comb
  begin
    for (int g = 0; g < nested_irq_pkg::NUM_GRP; g++)
    begin
      grp_set[g] = |(pin_edge & grp_pins[g]);
      grp_level[g] = |(pin_level & grp_pins[g]);
      grp_mask[g] = |(pin_forced_low_in & pin_irq_en_in & grp_pins[g]);
      grp_ack[g] = svc_entry_in & ~svc_nonmask_in
                   & (svc_vector_in == nested_irq_pkg::VEC_EXT0 + 4'(g));
    end
  end

  // a new edge wins over any clear in the same cycle
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ext_pend <= 3'h0;
    end
    else if (ce_in)
    begin
      ext_pend <= grp_set | (ext_pend & ~grp_ack & ~{3{sense_change}});
    end
  end

  assign ext_req_out = (ext_pend | grp_level) & ~grp_mask;

  //////////////////////////////////////////////////////////////////////////
  // halt exit

  logic [13:0] all_req;
  always_comb
  begin
    all_req = src_req_in;
    all_req[nested_irq_pkg::VEC_EXT0 +: 3] = ext_req_out;
  end

  assign halt_wake_out = |(all_req & nested_irq_pkg::HALT_WAKE_MASK);
  assign active_halt_wake_out = |(all_req & (nested_irq_pkg::HALT_WAKE_MASK
                                | nested_irq_pkg::AHALT_ONLY_MASK));

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  property p_level0_kept;
    wr_prio && reg_wdata_in[1:0] == nested_irq_pkg::CODE_L0
      |=> prio[$past(reg_addr_in[1:0])][1:0] == $past(prio[reg_addr_in[1:0]][1:0]);
  endproperty
  a_level0_kept: assert property (p_level0_kept) else $error("level 0 pair overwritten");

  property p_ro_nibble;
    reg_rd_in && ce_in && reg_addr_in == nested_irq_pkg::ADDR_PRIO3
      |=> reg_rdata_out[7:4] == 4'hf;
  endproperty
  a_ro_nibble: assert property (p_ro_nibble) else $error("read-only nibble not ones");

  property p_sense_locked;
    cur_level != nested_irq_pkg::CODE_L3 |=> $stable(sense_ctrl);
  endproperty
  a_sense_locked: assert property (p_sense_locked) else $error("sense changed below level 3");

  property p_disable_level;
    ce_in && !svc_entry_in && (disable_irq_instr_in || trap_instr_in)
      |=> cur_level == nested_irq_pkg::CODE_L3 && branch_if_level3_out;
  endproperty
  a_disable_level: assert property (p_disable_level) else $error("disable did not reach level 3");

  property p_enable_level;
    ce_in && !svc_entry_in && !disable_irq_instr_in && !trap_instr_in
      && enable_irq_instr_in |=> cur_level == nested_irq_pkg::CODE_L0;
  endproperty
  a_enable_level: assert property (p_enable_level) else $error("enable did not reach level 0");

  property p_top_entry;
    ce_in && svc_entry_in && svc_top |=> cur_level == nested_irq_pkg::CODE_L3;
  endproperty
  a_top_entry: assert property (p_top_entry) else $error("top source entry not level 3");

  property p_sense_clear;
    ce_in && sense_change && grp_set == 3'h0 |=> ext_pend == 3'h0;
  endproperty
  a_sense_clear: assert property (p_sense_clear) else $error("pending not cleared");

  property p_mask;
    grp_mask[0] |-> !ext_req_out[0];
  endproperty
  a_mask: assert property (p_mask) else $error("grounded pin did not mask group");

  property p_edge_once;
    ce_in && grp_set[1] |=> ext_pend[1];
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge not latched");

  property p_vec_addr;
    !svc_nonmask_in |-> svc_vector_addr_out[0] == 1'b0 && svc_vector_addr_out[15:5] == 11'h7ff;
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address out of map");

endmodule

/* File: sim/core_pin_model.sv */
// core and port pin model: instruction strobes and external interrupt pins
// assumes requests arrive by nonblocking assignment at the rising edge
`timescale 1ns/1ns
module core_pin_model (
  input wire logic mclk_in,
  input wire logic [2:0] op_in,
  input wire logic op_go_in,
  input wire logic [15:0] pin_lvl_in,
  output logic [6:0] instr_out,
  output logic [15:0] pin_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle one-hot strobe: enable, disable, trap, halt, wait, return, pop
  always_ff @(posedge mclk_in)
  begin
    instr_out <= op_go_in ? (7'h01 << op_in) : 7'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // pins move a few ns after the edge, unrelated to sampling
  initial pin_out = 16'hffff;
  always @(pin_lvl_in)
  begin
    pin_out <= #3 pin_lvl_in;
  end
endmodule

/* File: sim/tb.sv */
// self-checking bench for the priority and external sensitivity block
// assumes the core and pin model of core_pin_model.sv
`timescale 1ns/1ns
module tb;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wd = 8'h00;
  logic entry = 1'b0;
  logic nmask = 1'b0;
  logic pend = 1'b0;
  logic [3:0] vec = 4'h0;
  logic [1:0] stk = 2'h0;
  logic [15:0] pin_lvl = 16'hffff;
  logic [15:0] pin_en = 16'h0000;
  logic [15:0] forced = 16'h0000;
  logic [13:0] src = 14'h0000;
  logic [2:0] op = 3'h0;
  logic op_go = 1'b0;
  logic ce = 1'b1;
  logic [6:0] instr;
  logic [15:0] pins;
  logic [7:0] rdata;
  logic hi, lo, br3, brn3, reent, hw, ahw;
  logic [27:0] arb;
  logic [15:0] vaddr;
  logic [2:0] ereq;
  int err_count = 0;
  int cmp_count = 0;
  logic [7:0] pm [4];
  always #5 mclk_in = ~mclk_in;
  core_pin_model model (.mclk_in(mclk_in), .op_in(op), .op_go_in(op_go), .pin_lvl_in(pin_lvl),
    .instr_out(instr), .pin_out(pins));
  nested_irq_prio dut (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce), .reg_addr_in(addr),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .svc_entry_in(entry), .svc_nonmask_in(nmask), .svc_vector_in(vec), .svc_pending_in(pend),
    .enable_irq_instr_in(instr[0]), .disable_irq_instr_in(instr[1]), .trap_instr_in(instr[2]),
    .halt_instr_in(instr[3]), .wait_instr_in(instr[4]), .irq_return_instr_in(instr[5]),
    .pop_cc_instr_in(instr[6]), .stacked_level_in(stk), .ext_pin_in(pins),
    .pin_irq_en_in(pin_en), .pin_forced_low_in(forced), .src_req_in(src),
    .cur_level_hi_bit_out(hi), .cur_level_lo_bit_out(lo), .branch_if_level3_out(br3),
    .branch_if_not_level3_out(brn3), .arb_prio_codes_out(arb), .reenter_req_out(reent),
    .svc_vector_addr_out(vaddr), .ext_req_out(ereq), .halt_wake_out(hw),
    .active_halt_wake_out(ahw));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk1(input logic g, input logic e, input string m);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t %s got %b exp %b", $time, m, g, e);
    end
  endtask
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e, input string m);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_vec(input logic [27:0] g, input logic [27:0] e, input string m);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // expected register contents: level-0 pairs keep old value, top nibble of reg 3 fixed
  function automatic logic [7:0] merge(input logic [7:0] o, input logic [7:0] d, input int a);
    logic [7:0] r;
    r = d;
    for (int k = 0; k < 4; k++)
      if (d[2*k+:2] == 2'h2)
        r[2*k+:2] = o[2*k+:2];
    if (a == 3)
      r[7:4] = 4'hf;
    return r;
  endfunction
  // expected request after clear, after first and after second pin change
  function automatic logic [2:0] exp_req(input logic [1:0] c, input logic inv, input logic s);
    logic r, f, lo_, hi_, e0, e1;
    r = inv ? (c != 2'h1) : c[0];
    f = inv ? c[0] : (c != 2'h1);
    lo_ = !inv && c == 2'h0;
    hi_ = inv && c == 2'h0;
    e0 = s ? hi_ : lo_;
    // a level request is not latched, so it drops once the pin leaves it
    e1 = (s ? f : r) | (s ? lo_ : hi_);
    return {e0, e1, e1 | (s ? r : f) | e0};
  endfunction
  function automatic logic [27:0] exp_arb();
    logic [27:0] e;
    e[1:0] = 2'h3;
    for (int x = 1; x < 14; x++)
      e[2*x+:2] = pm[x/4][2*(x%4)+:2];
    return e;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic wrp(input int a, input logic [7:0] d);
    wreg(a[2:0], d);
    pm[a] = merge(pm[a], d, a);
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1 chk_reg(rdata, e, "read");
    @(posedge mclk_in);
  endtask
  task automatic chk_lvl(input logic [1:0] e);
    chk_vec({26'h0, hi, lo}, {26'h0, e}, "level");
    chk1(br3, e == 2'h3, "branch level3");
    chk1(brn3, e != 2'h3, "branch not level3");
  endtask
  task automatic op_do(input int c);
    op <= c[2:0];
    op_go <= 1'b1;
    @(posedge mclk_in);
    op_go <= 1'b0;
    @(posedge mclk_in);
    #1;
  endtask
  task automatic svc(input int v, input logic nm);
    vec <= v[3:0];
    nmask <= nm;
    entry <= 1'b1;
    #1;
    @(posedge mclk_in);
    entry <= 1'b0;
    #1;
  endtask
  task automatic ext_case(input int p, input int g, input logic pp, input logic [1:0] c,
    input logic pol, input logic s);
    logic [7:0] sv;
    logic [2:0] e;
    sv = {c, pol, c, c, pol};
    e = exp_req(c, pol & pp, s);
    pin_en <= 16'h0001 << p;
    pin_lvl <= ($urandom & ~(16'h0001 << p)) | (16'(s) << p);
    repeat (5) @(posedge mclk_in);
    op_do(1);
    wreg(3'h4, ~sv);
    wreg(3'h4, sv);
    #1 chk1(ereq[g], e[2], "cleared by sense change");
    pin_lvl[p] <= ~s;
    repeat (5) @(posedge mclk_in);
    #1 chk1(ereq[g], e[1], "first pin change");
    pin_lvl[p] <= s;
    repeat (5) @(posedge mclk_in);
    #1 chk1(ereq[g], e[0], "second pin change");
    forced[p] <= 1'b1;
    @(posedge mclk_in);
    #1 chk1(ereq[g], 1'b0, "forced low masks");
    forced[p] <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge mclk_in);
    err_count++;
    test_done();
  end
  initial
  begin
    int ops [5] = '{0, 1, 3, 2, 4};
    logic [1:0] exl [5] = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h2};
    int pl [5] = '{0, 3, 6, 10, 13};
    int gl [5] = '{0, 0, 1, 2, 2};
    logic ppl [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    int a;
    void'($urandom(32'hfe9fe7c9));
    for (int i = 0; i < 4; i++)
      pm[i] = 8'hff;
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    for (int i = 0; i < 4; i++)
      rd_chk(i[2:0], 8'hff);
    rd_chk(3'h4, 8'h00);
    for (int i = 5; i < 8; i++)
      rd_chk(i[2:0], 8'h00);
    chk_lvl(2'h3);
    chk_vec(arb, exp_arb(), "prio codes");
    wrp(0, 8'hcf);
    wrp(0, 8'h64);
    rd_chk(3'h0, 8'h44);
    wrp(3, 8'h00);
    rd_chk(3'h3, 8'hf0);
    // clock enable low: a write strobe must not be taken
    ce <= 1'b0;
    wreg(3'h1, 8'h00);
    ce <= 1'b1;
    rd_chk(3'h1, pm[1]);
    repeat (24)
    begin
      a = $urandom % 4;
      wrp(a, $urandom);
      rd_chk(a[2:0], pm[a]);
      chk_vec(arb, exp_arb(), "prio codes");
    end
    for (int i = 0; i < 5; i++)
    begin
      op_do(ops[i]);
      chk_lvl(exl[i]);
    end
    wreg(3'h4, 8'hff);
    rd_chk(3'h4, 8'h00);
    op_do(1);
    wreg(3'h4, 8'h5a);
    rd_chk(3'h4, 8'h5a);
    stk <= 2'h1;
    op_do(5);
    chk_lvl(2'h1);
    stk <= 2'h0;
    op_do(6);
    chk_lvl(2'h0);
    svc(0, 1'b1);
    chk_vec(vaddr, 28'hfffe, "reset vector");
    chk_lvl(2'h3);
    op_do(0);
    svc(1, 1'b1);
    chk_vec(vaddr, 28'hfffc, "trap vector");
    chk_lvl(2'h3);
    for (int x = 0; x < 14; x++)
    begin
      svc(x, 1'b0);
      chk_vec(vaddr, 28'hfffa - 2 * x, "source vector");
      chk_lvl(x == 0 ? 2'h3 : pm[x/4][2*(x%4)+:2]);
    end
    wrp(1, (pm[1] & 8'hf3) | 8'h04);
    svc(5, 1'b0);
    chk_lvl(2'h1);
    pend <= 1'b1;
    wrp(1, pm[1] & 8'hf3);
    #1 chk1(reent, 1'b1, "re-enter on raised level");
    pend <= 1'b0;
    @(posedge mclk_in);
    #1 chk1(reent, 1'b0, "no re-enter without pending");
    for (int x = 0; x < 14; x++)
      if (x < 2 || x > 4)
      begin
        src <= 14'h0001 << x;
        @(posedge mclk_in);
        #1 chk1(hw, dut_wake(x), "halt wake");
        chk1(ahw, dut_wake(x) | nested_irq_pkg::AHALT_ONLY_MASK[x], "active-halt wake");
      end
    src <= 14'h0000;
    for (int i = 0; i < 5; i++)
      for (int c = 0; c < 4; c++)
        for (int p = 0; p < 2; p++)
          for (int s = 0; s < 2; s++)
            ext_case(pl[i], gl[i], ppl[i], c[1:0], p[0], s[0]);
    test_done();
  end
  function automatic logic dut_wake(input int x);
    return nested_irq_pkg::HALT_WAKE_MASK[x];
  endfunction
endmodule
